// File: verilog/holding_brake_sequencer.sv
// Holding brake sequencer with rotation and deviation monitors, APB slave
//
// Operation
// - Rotation output high when speed above threshold
// - Alarm when deviation exceeds overflow threshold
// - Brake timing used only with brake enabled
// - Positive on-wait: release brake, wait, excite
// - Negative on-wait: excite, wait, release brake
// - Stopped servo off: hold power 10ms steps
// - Coasting: brake once speed below threshold
// - Coasting: brake once elapsed time exceeds brake wait
//
// The APB slave port is this design's own decision.
`include "holding_brake_map.svh"
`default_nettype none

module holding_brake_sequencer
#(
  parameter int unsigned ms_cycles = `MS_NS / `CLK_PERIOD_NS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic servo_on,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [31:0] position_deviation,
  output logic brake_output,
  output logic motor_excite,
  output logic rotation_detected,
  output logic overflow_alarm,
  output logic interrupt
);

  // ==========================================================
  // Helpers

  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag16

  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    mag32 = v[31] ? 32'(-v) : 32'(v);
  endfunction : mag32

  function automatic logic mapped(input logic [13:0] idx);
    mapped = (idx >= `ROT_THR_IDX && idx <= `BRK_WAIT_IDX) ||
      (idx >= `CTRL_IDX && idx <= `IRQ_MASK_IDX);
  endfunction : mapped

  // ==========================================================
  // Registers

  logic [15:0] rotation_threshold_param;
  logic [31:0] overflow_threshold_param;
  logic [15:0] on_wait_param;
  logic [15:0] off_wait_param;
  logic [15:0] brake_speed_param;
  logic [15:0] brake_wait_param;
  logic brake_function_en;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;

  logic [13:0] reg_idx;
  logic wr_access;
  logic rd_setup;

  assign reg_idx = paddr[15:2];
  assign wr_access = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(reg_idx);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rotation_threshold_param <= `ROT_THR_RST;
      overflow_threshold_param <= `OVF_THR_RST;
      on_wait_param <= `ON_WAIT_RST;
      off_wait_param <= `OFF_WAIT_RST;
      brake_speed_param <= `BRK_SPD_RST;
      brake_wait_param <= `BRK_WAIT_RST;
      brake_function_en <= `CTRL_RST;
      irq_mask <= `IRQ_MASK_RST;
    end
    else if (wr_access)
    begin
      unique case (reg_idx)
        `ROT_THR_IDX: rotation_threshold_param <= pwdata[15:0];
        `OVF_THR_IDX: overflow_threshold_param <= pwdata;
        `ON_WAIT_IDX: on_wait_param <= pwdata[15:0];
        `OFF_WAIT_IDX: off_wait_param <= pwdata[15:0];
        `BRK_SPD_IDX: brake_speed_param <= pwdata[15:0];
        `BRK_WAIT_IDX: brake_wait_param <= pwdata[15:0];
        `CTRL_IDX: brake_function_en <= pwdata[`CTRL_BRAKE_EN_BIT];
        `IRQ_MASK_IDX: irq_mask <= pwdata[2:0];
        default:
        begin
        end
      endcase
    end
  end

  // ==========================================================
  // Servo-on pin synchroniser

  logic on_s1;
  logic on_s2;
  logic on_s3;
  logic servo_on_level;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      on_s1 <= 1'b0;
      on_s2 <= 1'b0;
      on_s3 <= 1'b0;
    end
    else
    begin
      on_s1 <= servo_on;
      on_s2 <= on_s1;
      on_s3 <= on_s2;
    end
  end

  // Only an agreed level counts, so a single-cycle glitch is ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      servo_on_level <= 1'b0;
    else if (on_s2 == on_s3)
      servo_on_level <= on_s3;
  end

  // ==========================================================
  // Monitors

  logic [15:0] speed_mag;
  logic [31:0] dev_mag;

  assign speed_mag = mag16(motor_speed);
  assign dev_mag = mag32(position_deviation);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rotation_detected <= 1'b0;
      overflow_alarm <= 1'b0;
    end
    else
    begin
      rotation_detected <= speed_mag > rotation_threshold_param;
      overflow_alarm <= dev_mag > overflow_threshold_param;
    end
  end

  // ==========================================================
  // Millisecond timebase, restarted at every state change

  holding_brake_pkg::seq_state_type state;
  holding_brake_pkg::seq_state_type next_state;
  logic [31:0] tick_cnt;
  logic ms_tick;
  logic [19:0] elapsed_ms;
  logic state_change;

  assign state_change = next_state != state;
  assign ms_tick = tick_cnt == ms_cycles - 1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt <= 32'h0;
    else if (state_change || ms_tick)
      tick_cnt <= 32'h0;
    else
      tick_cnt <= tick_cnt + 32'h1;
  end

  // Saturates so a long wait never wraps back to zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      elapsed_ms <= 20'h0;
    else if (state_change)
      elapsed_ms <= 20'h0;
    else if (ms_tick && elapsed_ms != 20'hfffff)
      elapsed_ms <= elapsed_ms + 20'h1;
  end

  // ==========================================================
  // Sequencer

  logic [15:0] on_wait_mag;
  logic [19:0] off_wait_ms;
  logic [19:0] brake_wait_ms;
  logic on_wait_done;

  assign on_wait_mag = mag16(on_wait_param);
  assign on_wait_done = elapsed_ms >= {4'h0, on_wait_mag};
  assign off_wait_ms = 20'({4'h0, off_wait_param} * `TEN_MS_STEP);
  assign brake_wait_ms = 20'({4'h0, brake_wait_param} * `TEN_MS_STEP);

  always_comb
  begin
    next_state = state;
    unique case (state)
      holding_brake_pkg::st_off:
        if (servo_on_level)
        begin
          if (!brake_function_en || on_wait_param == 16'h0)
            next_state = holding_brake_pkg::st_run;
          else if (on_wait_param[15])
            next_state = holding_brake_pkg::st_on_excite_first;
          else
            next_state = holding_brake_pkg::st_on_brake_first;
        end
      holding_brake_pkg::st_on_brake_first:
        if (!servo_on_level)
          next_state = holding_brake_pkg::st_off;
        else if (on_wait_done)
          next_state = holding_brake_pkg::st_run;
      holding_brake_pkg::st_on_excite_first:
        if (!servo_on_level)
          next_state = holding_brake_pkg::st_off;
        else if (on_wait_done)
          next_state = holding_brake_pkg::st_run;
      holding_brake_pkg::st_run:
        if (!servo_on_level)
        begin
          if (!brake_function_en)
            next_state = holding_brake_pkg::st_off;
          else if (speed_mag < brake_speed_param)
            next_state = holding_brake_pkg::st_off_hold;
          else
            next_state = holding_brake_pkg::st_off_coast;
        end
      holding_brake_pkg::st_off_hold:
        if (elapsed_ms >= off_wait_ms)
          next_state = holding_brake_pkg::st_off;
      holding_brake_pkg::st_off_coast:
        if (speed_mag < brake_speed_param)
          next_state = holding_brake_pkg::st_off;
        else if (elapsed_ms > brake_wait_ms)
          next_state = holding_brake_pkg::st_off;
      default:
        next_state = holding_brake_pkg::st_off;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= holding_brake_pkg::st_off;
    else
      state <= next_state;
  end

  // Brake output high means brake released
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      brake_output <= 1'b0;
      motor_excite <= 1'b0;
    end
    else
    begin
      brake_output <= brake_function_en &&
        (next_state == holding_brake_pkg::st_on_brake_first ||
         next_state == holding_brake_pkg::st_run ||
         next_state == holding_brake_pkg::st_off_coast);
      motor_excite <=
        next_state == holding_brake_pkg::st_on_excite_first ||
        next_state == holding_brake_pkg::st_run ||
        next_state == holding_brake_pkg::st_off_hold;
    end
  end

  // ==========================================================
  // Interrupts

  logic ovf_prev;
  logic rot_prev;
  logic brk_prev;
  logic [2:0] irq_event;
  logic [2:0] irq_clear;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovf_prev <= 1'b0;
      rot_prev <= 1'b0;
      brk_prev <= 1'b0;
    end
    else
    begin
      ovf_prev <= overflow_alarm;
      rot_prev <= rotation_detected;
      brk_prev <= brake_output;
    end
  end

  always_comb
  begin
    irq_event = 3'h0;
    irq_event[`IRQ_OVF_BIT] = overflow_alarm && !ovf_prev;
    irq_event[`IRQ_ROT_BIT] = rotation_detected && !rot_prev;
    irq_event[`IRQ_BRK_BIT] = brake_output != brk_prev;
  end

  assign irq_clear = (wr_access && reg_idx == `IRQ_STAT_IDX) ?
    pwdata[2:0] : 3'h0;

  // A new event wins over a simultaneous clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= 3'h0;
    else
      irq_status <= (irq_status & ~irq_clear) | irq_event;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      interrupt <= 1'b0;
    else
      interrupt <= |(irq_status & irq_mask);
  end

  // ==========================================================
  // Read data, captured in the setup cycle

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd_setup)
    begin
      unique case (reg_idx)
        `ROT_THR_IDX: prdata <= {16'h0, rotation_threshold_param};
        `OVF_THR_IDX: prdata <= overflow_threshold_param;
        `ON_WAIT_IDX: prdata <= {16'h0, on_wait_param};
        `OFF_WAIT_IDX: prdata <= {16'h0, off_wait_param};
        `BRK_SPD_IDX: prdata <= {16'h0, brake_speed_param};
        `BRK_WAIT_IDX: prdata <= {16'h0, brake_wait_param};
        `CTRL_IDX: prdata <= {31'h0, brake_function_en};
        `STATUS_IDX: prdata <= {24'h0, state, motor_excite,
          brake_output, overflow_alarm, rotation_detected,
          servo_on_level};
        `IRQ_STAT_IDX: prdata <= {29'h0, irq_status};
        `IRQ_MASK_IDX: prdata <= {29'h0, irq_mask};
        default: prdata <= 32'h0;
      endcase
    end
  end

endmodule : holding_brake_sequencer

`default_nettype wire

// File: common/holding_brake_map.svh
// Register indices, fields, reset values and timing for the brake sequencer
`ifndef HOLDING_BRAKE_MAP_SVH
`define HOLDING_BRAKE_MAP_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define ROT_THR_IDX 14'h335b
`define OVF_THR_IDX 14'h335c
`define ON_WAIT_IDX 14'h335d
`define OFF_WAIT_IDX 14'h335e
`define BRK_SPD_IDX 14'h335f
`define BRK_WAIT_IDX 14'h3360
`define CTRL_IDX 14'h3370
`define STATUS_IDX 14'h3371
`define IRQ_STAT_IDX 14'h3372
`define IRQ_MASK_IDX 14'h3373

// ==========================================================
// Reset values
`define ROT_THR_RST 16'h0014
`define OVF_THR_RST 32'h0280_0000
`define ON_WAIT_RST 16'h0000
`define OFF_WAIT_RST 16'h0000
`define BRK_SPD_RST 16'h0064
`define BRK_WAIT_RST 16'h0032
`define CTRL_RST 1'h1
`define IRQ_MASK_RST 3'h0

// ==========================================================
// Field positions
`define CTRL_BRAKE_EN_BIT 0
`define IRQ_OVF_BIT 0
`define IRQ_ROT_BIT 1
`define IRQ_BRK_BIT 2

// ==========================================================
// Timing
`define CLK_PERIOD_NS 5
`define MS_NS 1000000
`define TEN_MS_STEP 20'h0000a

`endif

// File: common/holding_brake_pkg.sv
// Types shared by the holding brake sequencer
`default_nettype none

package holding_brake_pkg;

  typedef enum logic [2:0]
  {
    st_off,
    st_on_brake_first,
    st_on_excite_first,
    st_run,
    st_off_hold,
    st_off_coast
  } seq_state_type;

endpackage : holding_brake_pkg

`default_nettype wire

// File: sim/motor_model.sv
// Behavioural motor with holding brake and power stage
`default_nettype none

module motor_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic brake_output,
  input wire logic motor_excite,
  input wire logic signed [15:0] speed_cmd,
  output logic signed [15:0] motor_speed
);
  // ==========================================================
  // Speed follows the command only when powered and released;
  // unpowered and released it coasts down one rpm a cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      motor_speed <= 16'sh0000;
    else if (!brake_output)
      motor_speed <= 16'sh0000;
    else if (motor_excite)
      motor_speed <= speed_cmd;
    else if (motor_speed > 0)
      motor_speed <= motor_speed - 16'sh0001;
    else if (motor_speed < 0)
      motor_speed <= motor_speed + 16'sh0001;
  end
endmodule : motor_model

`default_nettype wire

// File: sim/holding_brake_monitor.sv
// Port checker for the holding brake sequencer
`include "holding_brake_map.svh"
`default_nettype none

module holding_brake_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic servo_on,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [31:0] position_deviation,
  input wire logic brake_output,
  input wire logic motor_excite,
  input wire logic rotation_detected,
  input wire logic overflow_alarm,
  input wire logic interrupt
);
  // ==========================================================
  // Shadow thresholds, updated at the same access edge
  logic [15:0] rot_thr;
  logic [31:0] ovf_thr;
  logic [15:0] spd_mag;
  logic [31:0] dev_mag;
  logic wr;
  logic mapped;
  assign wr = psel && penable && pwrite;
  assign mapped = paddr[15:2] inside {[14'h335b:14'h3360],
    [14'h3370:14'h3373]};
  assign spd_mag = motor_speed[15] ? -motor_speed : motor_speed;
  assign dev_mag = position_deviation[31] ? -position_deviation :
    position_deviation;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rot_thr <= `ROT_THR_RST;
    else if (wr && paddr[15:2] == `ROT_THR_IDX)
      rot_thr <= pwdata[15:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovf_thr <= `OVF_THR_RST;
    else if (wr && paddr[15:2] == `OVF_THR_IDX)
      ovf_thr <= pwdata;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_high_a: assert property (pready)
    else $error("pready low");
  slverr_map_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("pslverr wrong for index");
  slverr_data_a: assert property (
    psel && penable && !pwrite && pslverr |-> !prdata)
    else $error("unmapped read data not zero");
  rot_detect_a: assert property (
    rotation_detected == ($past(spd_mag) > $past(rot_thr)))
    else $error("rotation output wrong");
  ovf_alarm_a: assert property (
    overflow_alarm == ($past(dev_mag) > $past(ovf_thr)))
    else $error("overflow alarm wrong");
  brake_first_a: assert property (
    $rose(brake_output) && !motor_excite |=> !motor_excite [*8])
    else $error("excited too soon after release");
  excite_first_a: assert property (
    $rose(motor_excite) && !brake_output |=> !brake_output [*8])
    else $error("released too soon after excite");
  coast_brake_a: assert property (
    $fell(motor_excite) && brake_output |-> ##[1:1000] !brake_output)
    else $error("brake not engaged while coasting");
  excite_cause_a: assert property ($rose(motor_excite) |->
    $past(servo_on, 3))
    else $error("excite without servo on");
endmodule : holding_brake_monitor

bind holding_brake_sequencer holding_brake_monitor mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .servo_on(servo_on), .motor_speed(motor_speed),
  .position_deviation(position_deviation), .brake_output(brake_output),
  .motor_excite(motor_excite), .rotation_detected(rotation_detected),
  .overflow_alarm(overflow_alarm), .interrupt(interrupt));

`default_nettype wire

// File: sim/holding_brake_sequencer_tb_top.sv
// Self-checking bench for the holding brake sequencer
`include "holding_brake_map.svh"
`default_nettype none

module holding_brake_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, servo_on = 0, interrupt;
  logic signed [15:0] motor_speed, speed_cmd = '0;
  logic signed [31:0] position_deviation = '0;
  logic brake_output, motor_excite, rotation_detected, overflow_alarm;
  int num_errors = 0, total_checks = 0, cycles = 0, n;

  holding_brake_sequencer #(.ms_cycles(20)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .servo_on(servo_on), .motor_speed(motor_speed),
    .position_deviation(position_deviation), .brake_output(brake_output),
    .motor_excite(motor_excite), .rotation_detected(rotation_detected),
    .overflow_alarm(overflow_alarm), .interrupt(interrupt));
  motor_model motor (.pclk(pclk), .presetn(presetn),
    .brake_output(brake_output), .motor_excite(motor_excite),
    .speed_cmd(speed_cmd), .motor_speed(motor_speed));

  initial forever #2.5 pclk = ~pclk;

  // ==========================================================
  // Hang guard: the whole run needs about 1100 cycles
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      num_errors++;
      conclude();
    end
  end

  // ==========================================================
  // Tasks
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chkr(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chkr

  task automatic apb(input logic w, input logic [13:0] idx,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp);
    apb(0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // Waits for the brake (b=1) or the excite output to reach v
  task automatic wt(input logic b, input logic v);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((b ? brake_output : motor_excite) !== v && n < 5000);
  endtask : wt

  task automatic lvl(input logic [31:0] d, input logic e, input logic o);
    if (o)
      position_deviation <= d;
    else
      speed_cmd <= d[15:0];
    repeat (4) @(posedge pclk);
    chk(o ? overflow_alarm : rotation_detected, e);
  endtask : lvl

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rdchk(`ROT_THR_IDX, 32'h0000_0014);
    rdchk(`OVF_THR_IDX, 32'h0280_0000);
    rdchk(`ON_WAIT_IDX, 32'h0000_0000);
    rdchk(`OFF_WAIT_IDX, 32'h0000_0000);
    rdchk(`BRK_SPD_IDX, 32'h0000_0064);
    rdchk(`BRK_WAIT_IDX, 32'h0000_0032);
    rdchk(14'h3361, 32'h0000_0000);
    chk(err, 32'h1);
    apb(1, `BRK_WAIT_IDX, 32'h0000_0001);
    rdchk(`BRK_WAIT_IDX, 32'h0000_0001);
    $display("registers done");
    servo_on <= 1;
    wt(1, 1);
    chk(motor_excite, 1);
    lvl(32'h15, 1, 0);
    lvl(32'h14, 0, 0);
    lvl(32'hffeb, 1, 0);
    lvl(32'hffec, 0, 0);
    chk(interrupt, 0);
    apb(1, `IRQ_MASK_IDX, 32'h1);
    lvl(32'd41943040, 0, 1);
    chk(interrupt, 0);
    lvl(32'd41943041, 1, 1);
    chk(interrupt, 1);
    lvl(-32'sd41943041, 1, 1);
    apb(1, `IRQ_STAT_IDX, 32'h1);
    repeat (2) @(posedge pclk);
    chk(interrupt, 0);
    $display("monitors done");
    lvl(32'h0, 0, 0);
    apb(1, `OFF_WAIT_IDX, 32'h1);
    servo_on <= 0;
    wt(1, 0);
    chk(motor_excite, 1);
    wt(0, 0);
    chkr(n, 199, 203);
    apb(1, `ON_WAIT_IDX, 32'h2);
    servo_on <= 1;
    wt(1, 1);
    chk(motor_excite, 0);
    wt(0, 1);
    chkr(n, 39, 42);
    lvl(32'd500, 1, 0);
    servo_on <= 0;
    wt(0, 0);
    wt(1, 0);
    // Whole-ms timebase: the brake engages once 11 ms have elapsed
    chkr(n, 219, 223);
    apb(1, `ON_WAIT_IDX, 32'h0000_fffe);
    apb(1, `BRK_WAIT_IDX, 32'ha);
    servo_on <= 1;
    wt(0, 1);
    chk(brake_output, 0);
    wt(1, 1);
    chkr(n, 39, 42);
    repeat (8) @(posedge pclk);
    servo_on <= 0;
    wt(0, 0);
    wt(1, 0);
    chkr(n, 399, 405);
    $display("sequencing done");
    apb(1, `CTRL_IDX, 32'h0);
    servo_on <= 1;
    wt(0, 1);
    chkr(n, 3, 6);
    repeat (60) @(posedge pclk);
    chk(brake_output, 0);
    servo_on <= 0;
    wt(0, 0);
    chkr(n, 3, 6);
    $display("brake disabled done");
    conclude();
  end
endmodule : holding_brake_sequencer_tb_top

`default_nettype wire
